//--- hbd_pkg.sv
// package for the half-bridge input mode decoder
// assumes a single 10 MHz system clock
package hbd_pkg;
	localparam int unsigned CLK_FREQ_HZ   = 10_000_000;
	localparam int unsigned DEAD_TIME_NS  = 200;
	localparam int unsigned DEAD_CYCLES_I = (DEAD_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned DEAD_CYCLES   = (DEAD_CYCLES_I < 1) ? 1 : DEAD_CYCLES_I;
	localparam int unsigned DEAD_W        = 4;
	localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(DEAD_CYCLES);
	localparam logic [DEAD_W-1:0] DEAD_ZERO = 4'h0;
	localparam int unsigned NUM_PHASES    = 3;

	typedef enum logic [2:0] {
		HBD_MODE_6X      = 3'h0,
		HBD_MODE_3X      = 3'h1,
		HBD_MODE_1X      = 3'h2,
		HBD_MODE_IND_HB  = 3'h3,
		HBD_MODE_AB_HB   = 3'h4,
		HBD_MODE_BC_HB   = 3'h5,
		HBD_MODE_A_HB    = 3'h6,
		HBD_MODE_IND_FET = 3'h7
	} hbd_mode_t;

	// per-phase input pair and gate pair
	typedef struct packed {
		logic high_side_input;
		logic low_side_input;
	} hbd_phase_in_t;

	typedef struct packed {
		logic high_gate_cmd;
		logic low_gate_cmd;
	} hbd_gate_t;

	typedef hbd_phase_in_t [NUM_PHASES-1:0] hbd_in_bus_t;
	typedef hbd_gate_t     [NUM_PHASES-1:0] hbd_gate_bus_t;
endpackage

//--- hbd_dead_time.sv
// one phase: dead-time inserter between requested and driven gates
// assumes requests come from flops on the same clock
`timescale 1ns/1ns
module hbd_dead_time
	import hbd_pkg::*;
(
	// clock and reset
	input  wire logic      i_clock,
	input  wire logic      i_rst_n,
	// control
	input  wire logic      i_bypass,
	input  wire hbd_gate_t i_req,
	// gate out
	output hbd_gate_t      o_gate
);
	logic [DEAD_W-1:0] cnt_r;
	logic [DEAD_W-1:0] cnt_nxt;
	hbd_gate_t         gate_r;
	hbd_gate_t         gate_nxt;
	wire               hi_blocked;
	wire               lo_blocked;
	wire               cnt_busy;

	assign cnt_busy   = (cnt_r != DEAD_ZERO);
	// a gate may rise only after the other has been off for the whole gap
	assign hi_blocked = gate_r.low_gate_cmd | cnt_busy;
	assign lo_blocked = gate_r.high_gate_cmd | cnt_busy;

	always_comb begin
		gate_nxt = i_req;
		cnt_nxt  = cnt_busy ? cnt_r - 4'h1 : cnt_r;
		if (i_bypass) begin
			gate_nxt = i_req;
			cnt_nxt  = DEAD_ZERO;
		end else begin
			if (i_req.high_gate_cmd && hi_blocked && !gate_r.high_gate_cmd)
				gate_nxt.high_gate_cmd = 1'b0;
			if (i_req.low_gate_cmd && lo_blocked && !gate_r.low_gate_cmd)
				gate_nxt.low_gate_cmd = 1'b0;
			if ((gate_r.high_gate_cmd && !gate_nxt.high_gate_cmd) ||
			    (gate_r.low_gate_cmd && !gate_nxt.low_gate_cmd))
				cnt_nxt = DEAD_LOAD;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			gate_r <= '0;
			cnt_r  <= DEAD_ZERO;
		end else begin
			gate_r <= gate_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	assign o_gate = gate_r;

	a_no_overlap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!i_bypass && !$past(i_bypass) |-> !(gate_r.high_gate_cmd && gate_r.low_gate_cmd))
		else $error("both gates on without bypass");
	a_gap_kept: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!i_bypass && $fell(gate_r.low_gate_cmd) |=> !gate_r.high_gate_cmd)
		else $error("high gate rose without dead time");
	a_bypass_pass: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_bypass |=> gate_r == $past(i_req))
		else $error("bypass phase not passed through");
endmodule

//--- hbd_mode_decoder.sv
// top: mode decode, per-phase truth tables, dead time per phase
// assumes inputs synchronous to i_clock; mode held static while gates switch
`timescale 1ns/1ns
// Function
// - codes 000 six-input, 001 three-input, 010 block commutation, 011 independent half-bridge.
// - 101 A independent FET; 110 B,C independent FET; 111 all independent FET.
// - 100 A,B half-bridge, C independent FET; register variant only.
// - eight modes via register, seven via strap.
// - six-input: only high input on drives high gate, only low drives low.
// - six-input: both inputs equal keeps both gates off.
// - three-input: low-side input low forces both gates off.
// - three-input: low-side high, high-side input picks high or low gate.
// - half-bridge phases get automatic dead time between complementary gates.
// - independent half-bridge behaves like three-input decoding.
// - independent FET phases bypass dead time, both gates may be on.
module hbd_mode_decoder
	import hbd_pkg::*;
(
	// clock and reset
	input  wire logic          i_clock,
	input  wire logic          i_rst_n,
	// configuration
	input  wire hbd_mode_t     i_mode,
	input  wire logic          i_strap_variant,
	// controller inputs
	input  wire hbd_in_bus_t   i_phase_in,
	// gate commands and active mode
	output hbd_gate_bus_t      o_gate,
	output hbd_mode_t          o_mode_active
);
	import hbd_pkg::*;

	hbd_in_bus_t   in_r;
	hbd_mode_t     mode_r;
	hbd_mode_t     mode_nxt;
	hbd_gate_bus_t req_r;
	hbd_gate_bus_t req_nxt;
	logic [NUM_PHASES-1:0] fet_r;
	logic [NUM_PHASES-1:0] fet_nxt;

	// six-input table
	function automatic hbd_gate_t dec_6x(input hbd_phase_in_t p);
		hbd_gate_t g;
		g.high_gate_cmd = p.high_side_input & ~p.low_side_input;
		g.low_gate_cmd  = p.low_side_input & ~p.high_side_input;
		return g;
	endfunction

	// three-input table, shared by independent half-bridge
	function automatic hbd_gate_t dec_3x(input hbd_phase_in_t p);
		hbd_gate_t g;
		g.high_gate_cmd = p.low_side_input & p.high_side_input;
		g.low_gate_cmd  = p.low_side_input & ~p.high_side_input;
		return g;
	endfunction

	// direct FET control per input
	function automatic hbd_gate_t dec_fet(input hbd_phase_in_t p);
		hbd_gate_t g;
		g.high_gate_cmd = p.high_side_input;
		g.low_gate_cmd  = p.low_side_input;
		return g;
	endfunction

	// strap variant cannot select 100b; fall back to all-off decode
	wire mode_illegal = i_strap_variant && (i_mode == HBD_MODE_AB_HB);
	assign mode_nxt   = mode_illegal ? HBD_MODE_1X : i_mode;

	// block commutation not built here: it keeps every gate off
	always_comb begin
		req_nxt = '0;
		fet_nxt = '0;
		case (mode_r)
			HBD_MODE_6X: begin
				for (int i = 0; i < NUM_PHASES; i++)
					req_nxt[i] = dec_6x(in_r[i]);
			end
			HBD_MODE_3X, HBD_MODE_IND_HB: begin
				for (int i = 0; i < NUM_PHASES; i++)
					req_nxt[i] = dec_3x(in_r[i]);
			end
			HBD_MODE_1X: begin
				req_nxt = '0;
			end
			HBD_MODE_AB_HB: begin
				fet_nxt = 3'h4;
			end
			HBD_MODE_BC_HB: begin
				fet_nxt = 3'h1;
			end
			HBD_MODE_A_HB: begin
				fet_nxt = 3'h6;
			end
			HBD_MODE_IND_FET: begin
				fet_nxt = 3'h7;
			end
			default: begin
				req_nxt = '0;
			end
		endcase
		if (mode_r inside {HBD_MODE_AB_HB, HBD_MODE_BC_HB, HBD_MODE_A_HB, HBD_MODE_IND_FET}) begin
			for (int i = 0; i < NUM_PHASES; i++)
				req_nxt[i] = fet_nxt[i] ? dec_fet(in_r[i]) : dec_3x(in_r[i]);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			in_r          <= '0;
			mode_r        <= HBD_MODE_6X;
			req_r         <= '0;
			fet_r         <= '0;
			o_mode_active <= HBD_MODE_6X;
		end else begin
			in_r          <= i_phase_in;
			mode_r        <= mode_nxt;
			req_r         <= req_nxt;
			fet_r         <= fet_nxt;
			o_mode_active <= mode_r;
		end
	end

	// mode changes mid-switching are the controller's to avoid
	for (genvar g = 0; g < NUM_PHASES; g++) begin : g_phase
		hbd_dead_time u_dead (
			.i_clock (i_clock),
			.i_rst_n (i_rst_n),
			.i_bypass(fet_r[g]),
			.i_req   (req_r[g]),
			.o_gate  (o_gate[g])
		);
	end

	a_six_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mode_r == HBD_MODE_6X && (in_r[0].high_side_input == in_r[0].low_side_input) |=> req_r[0] == 2'h0)
		else $error("six-input equal inputs not off");
	a_six_high: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mode_r == HBD_MODE_6X && in_r[1].high_side_input && !in_r[1].low_side_input |=> req_r[1] == 2'h2)
		else $error("six-input high not decoded");
	a_three_float: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mode_r == HBD_MODE_3X && !in_r[2].low_side_input |=> req_r[2] == 2'h0)
		else $error("three-input float not off");
	a_three_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mode_r == HBD_MODE_IND_HB && in_r[0].low_side_input && !in_r[0].high_side_input |=> req_r[0] == 2'h1)
		else $error("half-bridge low gate not decoded");
	a_fet_map: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mode_r == HBD_MODE_BC_HB |=> fet_r == 3'h1)
		else $error("wrong independent phase set");
	a_strap_block: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_strap_variant && i_mode == HBD_MODE_AB_HB |=> mode_r != HBD_MODE_AB_HB)
		else $error("strap variant took code 100");
	a_reset_off: assert property (@(posedge i_clock)
		!i_rst_n |=> o_gate == '0)
		else $error("gates not off after reset");
	a_latency: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mode_r == HBD_MODE_IND_FET && $past(mode_r) == HBD_MODE_IND_FET && $past(mode_r, 2) == HBD_MODE_IND_FET
		|=> o_gate[2] == $past(dec_fet(in_r[2]), 2))
		else $error("independent FET path wrong");
endmodule

//--- hbd_ctrl_model.sv
// controller model driving the per-phase inputs
// assumes requests from the bench change just after rising edges
`timescale 1ns/1ns
module hbd_ctrl_model
	import hbd_pkg::*;
(
	// clock
	input  wire logic        i_clock,
	// requests from the bench
	input  wire hbd_mode_t   i_want_mode,
	input  wire hbd_in_bus_t i_want_in,
	// towards the decoder
	output hbd_mode_t        o_mode,
	output hbd_in_bus_t      o_phase_in
);
	int quiet;
	initial begin
		o_mode = HBD_MODE_6X;
		o_phase_in = '0;
		quiet = 0;
	end
	// inputs go low and stay low a while before the mode moves
	always @(posedge i_clock) begin
		#1;
		if (i_want_mode !== o_mode) begin
			o_phase_in = '0;
			quiet++;
			if (quiet > 2) begin
				o_mode = i_want_mode;
				quiet = 0;
			end
		end else begin
			o_phase_in = i_want_in;
		end
	end
endmodule

//--- hbd_mode_decoder_bench.sv
// self-checking bench for the mode decoder
// assumes the controller model owns the phase inputs and mode
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
	n_compared++; \
	if ((got) !== (ex)) begin \
		n_errors++; \
		$display("[ERR] %s expected %h seen %h", nm, ex, got); \
	end
module hbd_mode_decoder_bench;
	import hbd_pkg::*;
	typedef struct packed {
		hbd_mode_t     mode;
		logic          strap;
		hbd_in_bus_t   pin;
		hbd_gate_bus_t gate;
		hbd_mode_t     act;
	} hbd_row_t;
	logic          clock = 1'b0;
	logic          rst_n = 1'b0;
	logic          strap = 1'b0;
	hbd_mode_t     want_mode = HBD_MODE_6X;
	hbd_in_bus_t   want_in = '0;
	hbd_mode_t     mode;
	hbd_mode_t     act;
	hbd_in_bus_t   phase_in;
	hbd_gate_bus_t gate;
	int            n_errors = 0;
	int            n_compared = 0;
	int            both, fall, rise;
	// inputs C,B,A as {high,low}; C=11 B=01 A=10, row 1 C=00 B=11 A=01
	hbd_row_t rows[10] = '{
		'{HBD_MODE_6X, 1'b0, 6'h36, 6'h06, HBD_MODE_6X},
		'{HBD_MODE_6X, 1'b0, 6'h0D, 6'h01, HBD_MODE_6X},
		'{HBD_MODE_3X, 1'b0, 6'h36, 6'h24, HBD_MODE_3X},
		'{HBD_MODE_1X, 1'b0, 6'h36, 6'h00, HBD_MODE_1X},
		'{HBD_MODE_IND_HB, 1'b0, 6'h36, 6'h24, HBD_MODE_IND_HB},
		'{HBD_MODE_AB_HB, 1'b0, 6'h36, 6'h34, HBD_MODE_AB_HB},
		'{HBD_MODE_AB_HB, 1'b1, 6'h36, 6'h00, HBD_MODE_1X},
		'{HBD_MODE_BC_HB, 1'b0, 6'h36, 6'h26, HBD_MODE_BC_HB},
		'{HBD_MODE_A_HB, 1'b0, 6'h36, 6'h34, HBD_MODE_A_HB},
		'{HBD_MODE_IND_FET, 1'b0, 6'h36, 6'h36, HBD_MODE_IND_FET}
	};
	hbd_ctrl_model hbd_ctrl_model_i (
		.i_clock    (clock),
		.i_want_mode(want_mode),
		.i_want_in  (want_in),
		.o_mode     (mode),
		.o_phase_in (phase_in)
	);
	hbd_mode_decoder hbd_mode_decoder_i (
		.i_clock        (clock),
		.i_rst_n        (rst_n),
		.i_mode         (mode),
		.i_strap_variant(strap),
		.i_phase_in     (phase_in),
		.o_gate         (gate),
		.o_mode_active  (act)
	);
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// inputs parked low around every mode or strap change
	task automatic set_in(input hbd_mode_t m, input logic s, input hbd_in_bus_t v);
		want_in = '0;
		wait_n(6);
		want_mode = m;
		strap = s;
		wait_n(6);
		want_in = v;
		wait_n(8);
	endtask
	// phase A swings from high gate to low gate
	task automatic swing(input hbd_mode_t m);
		set_in(m, 1'b0, 6'h02);
		want_in = 6'h01;
		both = 0;
		fall = -1;
		rise = -1;
		for (int c = 0; c < 12; c++) begin
			wait_n(1);
			if (gate[0] === 2'h3) both++;
			if (fall < 0 && gate[0].high_gate_cmd === 1'b0) fall = c;
			if (rise < 0 && gate[0].low_gate_cmd === 1'b1) rise = c;
		end
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		print_verdict();
	end
	initial begin
		wait_n(6);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			set_in(rows[i].mode, rows[i].strap, rows[i].pin);
			`CHK("gate", rows[i].gate, gate)
			`CHK("mode", rows[i].act, act)
		end
		swing(HBD_MODE_6X);
		`CHK("overlap", 0, both)
		`CHK("gap", 1'b1, rise - fall >= int'(DEAD_CYCLES))
		swing(HBD_MODE_IND_FET);
		`CHK("bypass", 1'b1, rise == fall && rise >= 0)
		set_in(HBD_MODE_3X, 1'b0, 6'h37);
		`CHK("3x no float", 6'h26, gate)
		set_in(HBD_MODE_6X, 1'b0, 6'h02);
		rst_n = 1'b0;
		wait_n(1);
		`CHK("reset gate", 6'h00, gate)
		wait_n(5);
		rst_n = 1'b1;
		wait_n(8);
		`CHK("after reset", 6'h02, gate)
		print_verdict();
	end
endmodule
